/* File: verilog/mbexc_responder.v */
// Holding-register reader and exception frame builder for the slave.
`timescale 1ns/1ps
`include "mbexc_consts.vh"
module mbexc_responder #(
  parameter QTY_MAX = 125
) (
  // Clock and reset.
  input  wire        sys_clk,
  input  wire        reset,
  // Framing mode: high for TCP, low for RTU.
  input  wire        tcp_mode,
  // Request from the frame parser.
  input  wire        req_valid,
  output reg         req_ready_r,
  input  wire [7:0]  req_unit_id,
  input  wire [7:0]  req_function,
  input  wire [15:0] req_start_addr,
  input  wire [15:0] req_quantity,
  input  wire        req_error,
  input  wire [7:0]  req_error_code,
  // Live register sources.
  input  wire [15:0] flow_rate_value,
  input  wire [15:0] first_alarm_setpoint,
  input  wire [15:0] second_alarm_setpoint,
  input  wire [15:0] alarm_mode_select,
  input  wire [15:0] first_alarm_delay,
  input  wire [15:0] second_alarm_delay,
  // Byte stream of the response body.
  output reg         tx_valid_r,
  input  wire        tx_ready,
  output reg  [7:0]  tx_data_r,
  output reg         tx_last_r,
  // Status.
  output reg         exception_sent_r
);
  localparam S_IDLE = 3'd0;
  localparam S_HEAD = 3'd1;
  localparam S_DATA = 3'd2;
  localparam S_CRC  = 3'd3;
  localparam S_EXC  = 3'd4;

  reg [2:0]  state_r;
  reg [7:0]  unit_r;
  reg [7:0]  func_r;
  reg [7:0]  code_r;
  reg [15:0] addr_r;
  reg [15:0] left_r;
  reg [1:0]  idx_r;
  reg        hi_r;
  reg [15:0] crc_r;

  // Two-entry output buffer; a receiver stall simply stops the builder.
  reg [8:0]  buf1_r;
  reg [1:0]  cnt_r;
  wire       can_push = (cnt_r != 2'd2);
  wire       pop = tx_valid_r && tx_ready;

  // Register select by relative address.
  reg [15:0] rd_word;
  always @* begin
    case (addr_r)
      `MBEXC_ADDR_FLOW:    rd_word = flow_rate_value;
      `MBEXC_ADDR_AL_SET1: rd_word = first_alarm_setpoint;
      `MBEXC_ADDR_AL_SET2: rd_word = second_alarm_setpoint;
      `MBEXC_ADDR_MODE:    rd_word = alarm_mode_select;
      `MBEXC_ADDR_DELAY1:  rd_word = first_alarm_delay;
      `MBEXC_ADDR_DELAY2:  rd_word = second_alarm_delay;
      default:             rd_word = 16'h0000;
    endcase
  end

  // Address check; the wire address is already register number minus the base.
  wire [16:0] end_addr = {1'b0, req_start_addr} + {1'b0, req_quantity} - 17'h00001;
  wire        bad_addr = (req_quantity == 16'h0000) || (end_addr > {1'b0, `MBEXC_ADDR_LAST});
  wire        is_read  = (req_function == `MBEXC_FC_READ_HOLD) && (req_quantity <= QTY_MAX[15:0]);

  // Byte to be pushed this cycle, and whether this is the final one.
  reg [7:0] push_byte;
  reg       push_last;
  reg       push_en;
  always @* begin
    push_byte = 8'h00;
    push_last = 1'b0;
    push_en   = 1'b0;
    case (state_r)
      S_HEAD: begin
        push_en = can_push;
        case (idx_r)
          2'd0:    push_byte = unit_r;
          2'd1:    push_byte = func_r;
          default: push_byte = {left_r[6:0], 1'b0};
        endcase
      end
      S_EXC: begin
        push_en = can_push;
        case (idx_r)
          2'd0:    push_byte = unit_r;
          2'd1:    push_byte = func_r;
          default: push_byte = code_r;
        endcase
        push_last = tcp_mode && (idx_r == 2'd2);
      end
      S_DATA: begin
        push_en   = can_push;
        push_byte = hi_r ? rd_word[15:8] : rd_word[7:0];
        push_last = tcp_mode && !hi_r && (left_r == 16'h0001);
      end
      S_CRC: begin
        push_en   = can_push;
        push_byte = hi_r ? crc_r[15:8] : crc_r[7:0];
        push_last = hi_r;
      end
      default: push_en = 1'b0;
    endcase
  end

  // CRC-16 update over one byte, reflected polynomial.
  function [15:0] crc_step;
    input [15:0] c;
    input [7:0]  d;
    integer      k;
    reg   [15:0] t;
    begin
      t = c ^ {8'h00, d};
      for (k = 0; k < 8; k = k + 1) begin
        t = t[0] ? ((t >> 1) ^ `MBEXC_CRC_POLY) : (t >> 1);
      end
      crc_step = t;
    end
  endfunction

  // Sequencer. It refuses a new request until the previous frame is queued.
  always @(posedge sys_clk) begin
    if (reset) begin
      state_r          <= S_IDLE;
      req_ready_r      <= 1'b0;
      unit_r           <= 8'h00;
      func_r           <= 8'h00;
      code_r           <= 8'h00;
      addr_r           <= 16'h0000;
      left_r           <= 16'h0000;
      idx_r            <= 2'd0;
      hi_r             <= 1'b1;
      crc_r            <= `MBEXC_CRC_INIT;
      exception_sent_r <= 1'b0;
    end else begin
      req_ready_r      <= (state_r == S_IDLE) && !req_ready_r;
      exception_sent_r <= 1'b0;
      // The check value is frozen while it is sent, or the high byte would come from a changed sum.
      if (push_en && (state_r != S_CRC)) begin
        crc_r <= crc_step(crc_r, push_byte);
      end
      case (state_r)
        S_IDLE: begin
          if (req_valid && req_ready_r) begin
            unit_r <= req_unit_id;
            addr_r <= req_start_addr;
            left_r <= req_quantity;
            idx_r  <= 2'd0;
            hi_r   <= 1'b1;
            crc_r  <= `MBEXC_CRC_INIT;
            if (req_error || bad_addr || !is_read) begin
              func_r  <= req_function + `MBEXC_EXC_FLAG;
              code_r  <= req_error ? req_error_code : `MBEXC_EXC_ILLEGAL_ADR;
              state_r <= S_EXC;
            end else begin
              func_r  <= req_function;
              state_r <= S_HEAD;
            end
          end
        end
        S_HEAD: begin
          if (push_en) begin
            idx_r <= idx_r + 2'd1;
            if (idx_r == 2'd2) begin
              state_r <= S_DATA;
            end
          end
        end
        S_EXC: begin
          if (push_en) begin
            idx_r <= idx_r + 2'd1;
            if (idx_r == 2'd2) begin
              hi_r             <= 1'b0;
              exception_sent_r <= 1'b1;
              state_r          <= tcp_mode ? S_IDLE : S_CRC;
            end
          end
        end
        S_DATA: begin
          if (push_en) begin
            hi_r <= !hi_r;
            if (!hi_r) begin
              addr_r <= addr_r + 16'h0001;
              left_r <= left_r - 16'h0001;
              if (left_r == 16'h0001) begin
                hi_r    <= 1'b0;
                state_r <= tcp_mode ? S_IDLE : S_CRC;
              end
            end
          end
        end
        S_CRC: begin
          if (push_en) begin
            hi_r <= 1'b1;
            if (hi_r) begin
              state_r <= S_IDLE;
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Buffer storage: the output flops are the head entry, buf1_r the entry behind it.
  always @(posedge sys_clk) begin
    if (reset) begin
      buf1_r     <= 9'h000;
      cnt_r      <= 2'd0;
      tx_valid_r <= 1'b0;
      tx_data_r  <= 8'h00;
      tx_last_r  <= 1'b0;
    end else begin
      case ({push_en, pop})
        2'b10: begin
          if (cnt_r == 2'd0) begin
            tx_data_r <= push_byte;
            tx_last_r <= push_last;
          end else begin
            buf1_r <= {push_last, push_byte};
          end
          cnt_r      <= cnt_r + 2'd1;
          tx_valid_r <= 1'b1;
        end
        2'b01: begin
          tx_data_r  <= buf1_r[7:0];
          tx_last_r  <= buf1_r[8];
          cnt_r      <= cnt_r - 2'd1;
          tx_valid_r <= (cnt_r == 2'd2);
        end
        2'b11: begin
          if (cnt_r == 2'd1) begin
            tx_data_r <= push_byte;
            tx_last_r <= push_last;
          end else begin
            tx_data_r <= buf1_r[7:0];
            tx_last_r <= buf1_r[8];
            buf1_r    <= {push_last, push_byte};
          end
        end
        default: cnt_r <= cnt_r;
      endcase
    end
  end
endmodule

/* File: verilog/mbexc_consts.vh */
// Constants for the register-map and exception response builder.
// Function
// - A failed request is answered with an exception frame, not a normal response.
// - The error function code is the received function code plus 0x80.
// - RTU exception frame: unit id, error function, exception code, two check bytes.
// - A request naming a missing register gets exception code 0x02.
// - RTU frames end with CRC-16 low byte then high; TCP frames omit it.
// - Wire relative address equals documented register address minus 40001.
// - Relative address 0 returns the measured flow rate in millilitres.
// - Relative addresses 1 and 2 return the alarm set values, read-only.
// - Relative address 3 returns alarm mode: 0 high-high, 1 low-low, 2 high-low.
// - Relative addresses 4 and 5 return the alarm delay times in seconds.
`ifndef MBEXC_CONSTS_VH
`define MBEXC_CONSTS_VH
`define MBEXC_ADDR_FLOW       16'h0000
`define MBEXC_ADDR_AL_SET1    16'h0001
`define MBEXC_ADDR_AL_SET2    16'h0002
`define MBEXC_ADDR_MODE       16'h0003
`define MBEXC_ADDR_DELAY1     16'h0004
`define MBEXC_ADDR_DELAY2     16'h0005
`define MBEXC_ADDR_LAST       16'h0005
`define MBEXC_REG_BASE        17'h09c41
`define MBEXC_EXC_FLAG        8'h80
`define MBEXC_EXC_ILLEGAL_ADR 8'h02
`define MBEXC_CRC_INIT        16'hffff
`define MBEXC_CRC_POLY        16'ha001
`define MBEXC_FC_READ_HOLD    8'h03
`define MBEXC_FC_WRITE_ONE    8'h06
`define MBEXC_FC_WRITE_MANY   8'h10
`define MBEXC_FC_READ_WRITE   8'h17
`endif

/* File: test/mbexc_chk.sv */
// Port checker for the register reader and exception builder.
`timescale 1ns/1ps
`include "mbexc_consts.vh"
module mbexc_chk (
  // Clock and reset.
  input wire        sys_clk,
  input wire        reset,
  // Request side.
  input wire        tcp_mode,
  input wire        req_valid,
  input wire        req_ready_r,
  input wire [7:0]  req_unit_id,
  input wire [7:0]  req_function,
  input wire [15:0] req_start_addr,
  input wire [15:0] req_quantity,
  input wire        req_error,
  input wire [7:0]  req_error_code,
  // Stream side.
  input wire        tx_valid_r,
  input wire        tx_ready,
  input wire [7:0]  tx_data_r,
  input wire        tx_last_r,
  input wire        exception_sent_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  reg  [7:0]  cnt_r, unit_r, fc_r, code_r;
  reg         exc_r, tcp_r;
  wire        take = req_valid && req_ready_r;
  wire        beat = tx_valid_r && tx_ready;
  // Last register named; seventeen bits so that a run past the top cannot wrap round.
  wire [16:0] last_adr = {1'b0, req_start_addr} + {1'b0, req_quantity} - 17'h00001;
  // Only a read of 1 to 125 words inside the map escapes an exception.
  wire        fails = req_error || (req_function != `MBEXC_FC_READ_HOLD) || (req_quantity == 16'h0000) ||
                      (req_quantity > 16'h007d) || (last_adr > {1'b0, `MBEXC_ADDR_LAST});
  // Context is latched at the take edge, since the inputs may change once the request is gone.
  always @(posedge sys_clk) begin
    if (reset) begin
      cnt_r <= 8'h00;
      exc_r <= 1'b0;
      tcp_r <= 1'b0;
    end else if (take) begin
      cnt_r  <= 8'h00;
      exc_r  <= fails;
      tcp_r  <= tcp_mode;
      unit_r <= req_unit_id;
      fc_r   <= req_function;
      code_r <= req_error ? req_error_code : `MBEXC_EXC_ILLEGAL_ADR;
    end else if (beat) cnt_r <= cnt_r + 8'h01;
  end
  AST_ANSWER: assert property (take |-> ##2 tx_valid_r) else $error("No first byte.");
  AST_ONE_FRAME: assert property (take |=> !req_ready_r) else $error("Ready while busy.");
  AST_HOLD: assert property (tx_valid_r && !tx_ready |=> tx_valid_r && $stable(tx_data_r))
    else $error("Byte lost.");
  AST_UNIT: assert property (beat && cnt_r == 8'h00 |-> tx_data_r == unit_r) else $error("Bad unit byte.");
  AST_ERR_FC: assert property (beat && exc_r && cnt_r == 8'h01 |-> tx_data_r == 8'(fc_r + `MBEXC_EXC_FLAG))
    else $error("Bad error function.");
  AST_CODE: assert property (beat && exc_r && cnt_r == 8'h02 |-> tx_data_r == code_r) else $error("Bad code.");
  AST_LEN: assert property (beat && exc_r && tx_last_r |-> cnt_r == (tcp_r ? 8'h02 : 8'h04))
    else $error("Bad frame length.");
  AST_RESET: assert property (disable iff (1'b0) reset |=> !tx_valid_r && !req_ready_r && !exception_sent_r)
    else $error("Outputs not cleared.");
  AST_EXC_SENT: assert property (exception_sent_r |-> exc_r) else $error("Exception flag on a good read.");
  // Main scenarios.
  cover property (take && tcp_mode);
  cover property (beat && exc_r && tx_last_r && !tcp_r);
  cover property (beat && !exc_r && tx_last_r && !tcp_r);
  cover property (tx_valid_r && !tx_ready);
endmodule
bind mbexc_responder mbexc_chk u_chk (.*);

/* File: test/mbexc_sink.sv */
// Byte sink standing in for the master side of the stream.
`timescale 1ns/1ps
module mbexc_sink (
  // Clock and stream.
  input  wire       sys_clk,
  input  wire       stall,
  input  wire       tx_valid_r,
  input  wire [7:0] tx_data_r,
  input  wire       tx_last_r,
  output reg        tx_ready
);
  logic [7:0] q[$];
  int         ph = 0;
  bit         done = 1'b0;
  initial tx_ready = 1'b0;
  // A byte counts only on an edge where both sides agree.
  always @(posedge sys_clk) begin
    if (tx_valid_r && tx_ready) begin
      q.push_back(tx_data_r);
      if (tx_last_r) done = 1'b1;
    end
  end
  // Refusing one edge in three forces the buffer to hold its head.
  always @(negedge sys_clk) begin
    ph = (ph + 1) % 3;
    tx_ready = !(stall && ph == 0);
  end
endmodule

/* File: test/mbexc_responder_bench.sv */
// Self-checking bench for the register reader and exception builder.
`timescale 1ns/1ps
module mbexc_responder_bench;
  logic        sys_clk = 1'b0, reset = 1'b1, tcp_mode = 1'b0, req_valid = 1'b0, req_error = 1'b0, stall = 1'b1;
  logic [7:0]  req_unit_id = 8'h00, req_function = 8'h00, req_error_code = 8'h00, tx_data_r;
  logic [15:0] req_start_addr = 16'h0000, req_quantity = 16'h0000, alarm_mode_select = 16'h0001;
  logic [15:0] flow_rate_value = 16'h01f4, first_alarm_setpoint = 16'h0019, second_alarm_setpoint = 16'h0028;
  logic [15:0] first_alarm_delay = 16'h0005, second_alarm_delay = 16'h000a;
  logic        req_ready_r, tx_valid_r, tx_last_r, exception_sent_r, tx_ready;
  logic [7:0]  e[$];
  int          error_cnt = 0, n_checks = 0, n_exc = 0;
  always #2 sys_clk = ~sys_clk;
  mbexc_responder dut (.*);
  mbexc_sink u_sink (.*);
  // Exception pulses of the current frame; the pulse lasts one cycle, so each edge counts once.
  always @(posedge sys_clk) begin
    if (exception_sent_r === 1'b1) n_exc++;
  end
  task automatic chk(input logic [7:0] g, x);
    n_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // Reference check sum over the expected bytes: reflected polynomial, all-ones start.
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction
  task automatic end_sim;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Ready is looked at between edges; the request is dropped after the edge that takes it.
  task automatic frame(input logic md, input logic [7:0] u, f, input logic [15:0] a, n,
                       input logic er, input logic [7:0] cd);
    int k;
    @(negedge sys_clk);
    u_sink.q.delete();
    u_sink.done = 1'b0;
    n_exc = 0;
    {tcp_mode, req_unit_id, req_function, req_start_addr, req_quantity} = {md, u, f, a, n};
    {req_error, req_error_code, req_valid} = {er, cd, 1'b1};
    k = 0;
    while (req_ready_r !== 1'b1 && k < 50) begin
      @(negedge sys_clk);
      k++;
    end
    @(negedge sys_clk) req_valid = 1'b0;
    for (k = 0; k < 300 && !u_sink.done; k++) @(posedge sys_clk);
    #1;
    chk({7'h00, u_sink.done}, 8'h01);
    chk(8'(n_exc), {7'h00, e[1][7]});
    chk(8'(u_sink.q.size()), 8'(e.size()));
    foreach (e[i]) chk(u_sink.q[i], e[i]);
  endtask
  // All six words in one read, with the sink stalling.
  task automatic t_map;
    e = '{8'h01, 8'h03, 8'h0c, 8'h01, 8'hf4, 8'h00, 8'h19, 8'h00, 8'h28, 8'h00, 8'h01, 8'h00, 8'h05, 8'h00, 8'h0a};
    frame(1'b1, 8'h01, 8'h03, 16'(40001 - 40001), 16'h0006, 1'b0, 8'h00);
  endtask
  // Every alarm mode code without stalls; the last one is read in RTU framing, check bytes included.
  task automatic t_modes;
    for (int m = 0; m < 3; m++) begin
      logic [15:0] c;
      @(negedge sys_clk) {stall, alarm_mode_select} = {1'b0, 16'(m)};
      e = '{8'h01, 8'h03, 8'h02, 8'h00, 8'(m)};
      c = crc16(e);
      if (m == 2) begin
        e.push_back(c[7:0]);
        e.push_back(c[15:8]);
      end
      frame(1'(m != 2), 8'h01, 8'h03, 16'(40004 - 40001), 16'h0001, 1'b0, 8'h00);
    end
  endtask
  // Write to a missing register in RTU framing, check bytes included.
  task automatic t_exc_rtu;
    e = '{8'h03, 8'h90, 8'h02, 8'h6c, 8'h01};
    frame(1'b0, 8'h03, 8'h10, 16'(40100 - 40001), 16'h0002, 1'b0, 8'h00);
  endtask
  // A flagged error and a read running past the map, both in TCP framing.
  task automatic t_exc_tcp;
    e = '{8'h07, 8'h86, 8'h01};
    frame(1'b1, 8'h07, 8'h06, 16'h0000, 16'h0001, 1'b1, 8'h01);
    e = '{8'h01, 8'h83, 8'h02};
    frame(1'b1, 8'h01, 8'h03, 16'h0005, 16'h0002, 1'b0, 8'h00);
  endtask
  initial begin
    repeat (5) @(negedge sys_clk);
    reset = 1'b0;
    t_map;
    t_modes;
    t_exc_rtu;
    t_exc_tcp;
    end_sim;
  end
  // Guard against a hang; the tests need well under a tenth of this.
  initial begin
    #40000;
    error_cnt++;
    end_sim;
  end
endmodule
